/* File: oat_chk.sv */
`default_nettype none
`include "oat_consts.vh"
module oat_chk (
	// clock and reset
	input wire logic        mclk_i,
	input wire logic        rst_i,
	// request
	input wire logic        start_i,
	input wire logic [3:0]  op_i,
	input wire logic [2:0]  mode_i,
	input wire logic [2:0]  src_i,
	input wire logic [7:0]  oper_addr_i,
	input wire logic [7:0]  pointer_register_i,
	input wire logic [15:0] data_pointer_reg_i,
	input wire logic [7:0]  acc_i,
	// resolved access
	input wire logic [2:0]  space_o,
	input wire logic [15:0] addr_o,
	input wire logic        wr_o,
	input wire logic [1:0]  bytes_o,
	input wire logic [3:0]  cycles_o,
	input wire logic        busy_o,
	input wire logic        done_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	wire tk = start_i & ~busy_o;
	sfr_route_a: assert property (tk && mode_i == `OAT_M_DIRECT && oper_addr_i[7]
		|=> space_o == `OAT_SP_SFR) else $error("direct upper half not in sfr space");
	dir_low_a: assert property (tk && mode_i == `OAT_M_DIRECT && !oper_addr_i[7]
		|=> space_o == `OAT_SP_IRAM && addr_o == {8'h00, $past(oper_addr_i)})
		else $error("direct lower half not in ram");
	iram_route_a: assert property (tk && mode_i == `OAT_M_INDIRECT
		|=> space_o == `OAT_SP_IRAM && addr_o == {8'h00, $past(oper_addr_i)})
		else $error("indirect access not in ram");
	xdir_addr_a: assert property (tk && mode_i == `OAT_M_XDIRECT
		|=> space_o == `OAT_SP_EXTENDED_RAM && addr_o == ($past(data_pointer_reg_i) & 16'h07ff))
		else $error("bad extended direct address");
	xind_addr_a: assert property (tk && mode_i == `OAT_M_XINDIRECT
		|=> space_o == `OAT_SP_EXTENDED_RAM && addr_o == {8'h00, $past(pointer_register_i)})
		else $error("bad extended indirect address");
	code_addr_a: assert property (tk && mode_i == `OAT_M_CODEIDX
		|=> space_o == `OAT_SP_CODE && addr_o == $past(data_pointer_reg_i) + {8'h00, $past(acc_i)})
		else $error("bad code address");
	xmove_time_a: assert property (tk && op_i == `OAT_OP_XMOVE
		|=> (bytes_o == 2'h1 && cycles_o == 4'h4) ##0 busy_o [*3] ##1 (done_o && !busy_o))
		else $error("extended move timing");
	mul_time_a: assert property (tk && (op_i == `OAT_OP_MUL || op_i == `OAT_OP_DIV)
		|=> (cycles_o == 4'h9 && !done_o) [*8] ##1 done_o) else $error("multiply timing");
	logic_imm_a: assert property (tk && src_i == `OAT_S_DIR_IMM && op_i >= `OAT_OP_AND
		&& op_i <= `OAT_OP_XOR |=> (bytes_o == 2'h3 && cycles_o == 4'h3 && wr_o) ##2 done_o)
		else $error("logic immediate to direct");
	cover property (tk && op_i == `OAT_OP_MUL);
	cover property (tk && mode_i == `OAT_M_CODEIDX);
	cover property (start_i && busy_o);
endmodule
bind oat_core oat_chk u_oat_chk (.*);
`default_nettype wire

/* File: oat_consts.vh */
`ifndef OAT_CONSTS_VH
`define OAT_CONSTS_VH
// address spaces
`define OAT_SP_IRAM     3'h0
`define OAT_SP_SFR      3'h1
`define OAT_SP_EXTENDED_RAM     3'h2
`define OAT_SP_CODE     3'h3
`define OAT_SP_NONE     3'h4
// addressing modes
`define OAT_M_DIRECT    3'h0
`define OAT_M_INDIRECT  3'h1
`define OAT_M_XDIRECT   3'h2
`define OAT_M_XINDIRECT 3'h3
`define OAT_M_CODEIDX   3'h4
`define OAT_M_NONE      3'h5
// operation classes
`define OAT_OP_ADD      4'h0
`define OAT_OP_ADD_WITH_CARRY_OP     4'h1
`define OAT_OP_SUBTRACT_BORROW_OP     4'h2
`define OAT_OP_INC      4'h3
`define OAT_OP_DEC      4'h4
`define OAT_OP_INCDP    4'h5
`define OAT_OP_MUL      4'h6
`define OAT_OP_DIV      4'h7
`define OAT_OP_AND      4'h8
`define OAT_OP_OR       4'h9
`define OAT_OP_XOR      4'ha
`define OAT_OP_XMOVE    4'hb
`define OAT_OP_CFETCH   4'hc
// source / destination kinds
`define OAT_S_ACC       3'h0
`define OAT_S_BANK      3'h1
`define OAT_S_IND       3'h2
`define OAT_S_DIR       3'h3
`define OAT_S_IMM       3'h4
`define OAT_S_DIR_ACC   3'h5
`define OAT_S_DIR_IMM   3'h6
// counts
`define OAT_CYC_ONE     4'h1
`define OAT_CYC_TWO     4'h2
`define OAT_CYC_THREE   4'h3
`define OAT_CYC_FOUR    4'h4
`define OAT_CYC_NINE    4'h9
`define OAT_BYTES_ONE   2'h1
`define OAT_BYTES_TWO   2'h2
`define OAT_BYTES_THREE 2'h3
`define OAT_UPPER_BIT   7
`define OAT_EXTENDED_RAM_AW     11
`define OAT_CODE_AW     16
`endif

/* File: oat_core.v */
// Functional notes
// - direct upper-half address goes to function space
// - indirect upper-half address goes to RAM
// - lower half same RAM either mode
// - extended direct uses data pointer address
// - extended indirect uses named pointer register
// - external moves reach only 2 kB RAM
// - code address is accumulator plus pointer
// - add group byte and cycle counts
// - subtract with borrow, add-group counts
// - increment/decrement counts; pointer increment three
// - one/two cycles typical; multiply/divide nine
// - logic immediate to direct: three/three, writeback
// - logic accumulator to direct: two/two, writeback
// - extended move one byte, four cycles
// - code-indexed read one byte, four cycles
`default_nettype none
`include "oat_consts.vh"
module oat_core #(
	parameter EXTENDED_RAM_AW = `OAT_EXTENDED_RAM_AW,
	parameter CODE_AW = `OAT_CODE_AW
) (
	// clock and reset
	input  wire                 mclk_i,
	input  wire                 rst_i,
	// request
	input  wire                 start_i,
	input  wire [3:0]           op_i,
	input  wire [2:0]           mode_i,
	input  wire [2:0]           src_i,
	input  wire                 borrow_i,
	// operand sources
	input  wire [7:0]           oper_addr_i,
	input  wire [7:0]           pointer_register_i,
	input  wire [15:0]          data_pointer_reg_i,
	input  wire [7:0]           acc_i,
	input  wire [7:0]           imm_i,
	input  wire [7:0]           mem_data_i,
	// resolved access
	output reg  [2:0]           space_o,
	output reg  [15:0]          addr_o,
	output reg                  wr_o,
	output reg                  result_to_mem_o,
	output reg  [7:0]           alu_o,
	output reg                  carry_o,
	output reg  [1:0]           bytes_o,
	output reg  [3:0]           cycles_o,
	// sequencing
	output wire                 busy_o,
	output reg                  done_o
);
	localparam ST_IDLE = 1'b0;
	localparam ST_RUN  = 1'b1;

	reg        state_q;
	reg  [3:0] cnt_q;
	wire [1:0] t_bytes;
	wire [3:0] t_cycles;

	oat_timing u_timing (
		.op_i     (op_i),
		.src_i    (src_i),
		.bytes_o  (t_bytes),
		.cycles_o (t_cycles)
	);

	// decoding of the 8-bit internal space per mode
	function [2:0] int_space;
		input [2:0] m;
		input [7:0] a;
		begin
			if (m == `OAT_M_DIRECT && a[`OAT_UPPER_BIT])
				int_space = `OAT_SP_SFR;
			else
				int_space = `OAT_SP_IRAM;
		end
	endfunction

	reg [2:0]  space_d;
	reg [15:0] addr_d;
	reg [8:0]  sum_d;
	reg [7:0]  alu_d;
	reg        to_mem_d;
	reg [7:0]  opnd;

	always @* begin
		space_d = `OAT_SP_NONE;
		addr_d  = 16'h0000;
		case (mode_i)
		`OAT_M_DIRECT, `OAT_M_INDIRECT: begin
			space_d = int_space(mode_i, oper_addr_i);
			addr_d  = {8'h00, oper_addr_i};
		end
		`OAT_M_XDIRECT: begin
			space_d = `OAT_SP_EXTENDED_RAM;
			addr_d  = {{(16 - EXTENDED_RAM_AW){1'b0}}, data_pointer_reg_i[EXTENDED_RAM_AW-1:0]};
		end
		`OAT_M_XINDIRECT: begin
			space_d = `OAT_SP_EXTENDED_RAM;
			addr_d  = {8'h00, pointer_register_i};
		end
		`OAT_M_CODEIDX: begin
			space_d = `OAT_SP_CODE;
			addr_d  = data_pointer_reg_i + {8'h00, acc_i};
		end
		default: begin
			space_d = `OAT_SP_NONE;
			addr_d  = 16'h0000;
		end
		endcase
	end

	always @* begin
		opnd     = (src_i == `OAT_S_IMM || src_i == `OAT_S_DIR_IMM) ? imm_i : mem_data_i;
		sum_d    = 9'h000;
		alu_d    = 8'h00;
		to_mem_d = 1'b0;
		case (op_i)
		`OAT_OP_ADD: begin
			sum_d = {1'b0, acc_i} + {1'b0, opnd};
			alu_d = sum_d[7:0];
		end
		`OAT_OP_ADD_WITH_CARRY_OP: begin
			sum_d = {1'b0, acc_i} + {1'b0, opnd} + {8'h00, borrow_i};
			alu_d = sum_d[7:0];
		end
		`OAT_OP_SUBTRACT_BORROW_OP: begin
			sum_d = {1'b0, acc_i} - {1'b0, opnd} - {8'h00, borrow_i};
			alu_d = sum_d[7:0];
		end
		`OAT_OP_INC: alu_d = (src_i == `OAT_S_ACC) ? acc_i + 8'h01 : mem_data_i + 8'h01;
		`OAT_OP_DEC: alu_d = (src_i == `OAT_S_ACC) ? acc_i - 8'h01 : mem_data_i - 8'h01;
		`OAT_OP_AND: alu_d = (src_i == `OAT_S_DIR_IMM) ? (mem_data_i & imm_i) : (acc_i & opnd);
		`OAT_OP_OR:  alu_d = (src_i == `OAT_S_DIR_IMM) ? (mem_data_i | imm_i) : (acc_i | opnd);
		`OAT_OP_XOR: alu_d = (src_i == `OAT_S_DIR_IMM) ? (mem_data_i ^ imm_i) : (acc_i ^ opnd);
		default: alu_d = mem_data_i;
		endcase
		if ((op_i == `OAT_OP_AND || op_i == `OAT_OP_OR || op_i == `OAT_OP_XOR) &&
		    (src_i == `OAT_S_DIR_ACC || src_i == `OAT_S_DIR_IMM))
			to_mem_d = 1'b1;
		if ((op_i == `OAT_OP_INC || op_i == `OAT_OP_DEC) && src_i != `OAT_S_ACC &&
		    src_i != `OAT_S_BANK)
			to_mem_d = 1'b1;
	end

	assign busy_o = (state_q == ST_RUN);

	always @(posedge mclk_i) begin
		if (rst_i) begin
			state_q         <= ST_IDLE;
			cnt_q           <= 4'h0;
			space_o         <= `OAT_SP_NONE;
			addr_o          <= 16'h0000;
			wr_o            <= 1'b0;
			result_to_mem_o <= 1'b0;
			alu_o           <= 8'h00;
			carry_o         <= 1'b0;
			bytes_o         <= 2'h0;
			cycles_o        <= 4'h0;
			done_o          <= 1'b0;
		end else begin
			done_o <= 1'b0;
			case (state_q)
			ST_IDLE: begin
				if (start_i) begin
					space_o         <= space_d;
					addr_o          <= addr_d;
					wr_o            <= to_mem_d;
					result_to_mem_o <= to_mem_d;
					alu_o           <= alu_d;
					carry_o         <= sum_d[8];
					bytes_o         <= t_bytes;
					cycles_o        <= t_cycles;
					if (t_cycles == `OAT_CYC_ONE) begin
						done_o <= 1'b1;
					end else begin
						cnt_q   <= t_cycles - `OAT_CYC_ONE;
						state_q <= ST_RUN;
					end
				end
			end
			ST_RUN: begin
				if (cnt_q == `OAT_CYC_ONE) begin
					done_o  <= 1'b1;
					state_q <= ST_IDLE;
				end
				cnt_q <= cnt_q - `OAT_CYC_ONE;
			end
			default: state_q <= ST_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: oat_core_tb.sv */
`default_nettype none
`include "oat_consts.vh"
module oat_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic        ms;
		logic [2:0]  sp;
		logic [15:0] ad;
		logic [5:0]  bc;
		logic        mw;
		logic        wr;
		logic        ma;
		logic [8:0]  al;
	} oat_exp_t;
	logic        mclk_i = 0, rst_i = 1, start_i = 0, borrow_i = 0;
	logic [3:0]  op_i = 0;
	logic [2:0]  mode_i = 0, src_i = 0, space_o;
	logic [7:0]  oper_addr_i = 0, pointer_register_i = 0, acc_i = 0, imm_i = 0, mem_data_i = 0;
	logic [15:0] data_pointer_reg_i = 0, addr_o;
	logic        wr_o, result_to_mem_o, carry_o, busy_o, done_o;
	logic [7:0]  alu_o;
	logic [1:0]  bytes_o;
	logic [3:0]  cycles_o;
	int          n_mismatch = 0, checked = 0;
	oat_exp_t    q[$];
	oat_core u_oat_core (.*);
	always #2.5 mclk_i = ~mclk_i;
	task automatic fail(input string m);
		n_mismatch++;
		$display("[ERR] %0t %s", $time, m);
	endtask
	task automatic tally_and_finish;
		$display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic issue(input logic [3:0] op, input logic [2:0] src, input logic hold,
		input logic [7:0] a);
		oat_exp_t e;
		int k;
		logic [2:0] md;
		logic [7:0] opd;
		{pointer_register_i, acc_i, imm_i} = 24'($urandom);
		{data_pointer_reg_i, mem_data_i, borrow_i} = 25'($urandom);
		oper_addr_i = a;
		op_i = op;
		src_i = src;
		md = src == `OAT_S_IND ? `OAT_M_INDIRECT : `OAT_M_NONE;
		if (src inside {`OAT_S_DIR, `OAT_S_DIR_ACC, `OAT_S_DIR_IMM}) md = `OAT_M_DIRECT;
		if (op == `OAT_OP_XMOVE) md = a[0] ? `OAT_M_XDIRECT : `OAT_M_XINDIRECT;
		if (op == `OAT_OP_CFETCH) md = `OAT_M_CODEIDX;
		mode_i = md;
		e.ms = md != `OAT_M_NONE;
		e.sp = md == `OAT_M_DIRECT && a[7] ? `OAT_SP_SFR : `OAT_SP_IRAM;
		e.ad = {8'h00, a};
		case (md)
		`OAT_M_XDIRECT: {e.sp, e.ad} = {`OAT_SP_EXTENDED_RAM, 5'h00, data_pointer_reg_i[10:0]};
		`OAT_M_XINDIRECT: {e.sp, e.ad} = {`OAT_SP_EXTENDED_RAM, 8'h00, pointer_register_i};
		`OAT_M_CODEIDX: {e.sp, e.ad} = {`OAT_SP_CODE, data_pointer_reg_i + {8'h00, acc_i}};
		endcase
		case (src)
		`OAT_S_ACC, `OAT_S_BANK: e.bc = 6'h11;
		`OAT_S_IND: e.bc = 6'h12;
		`OAT_S_DIR_IMM: e.bc = 6'h33;
		default: e.bc = 6'h22;
		endcase
		case (op)
		`OAT_OP_INCDP: e.bc = 6'h13;
		`OAT_OP_MUL, `OAT_OP_DIV: e.bc = 6'h19;
		`OAT_OP_XMOVE, `OAT_OP_CFETCH: e.bc = 6'h14;
		endcase
		e.wr = src inside {`OAT_S_DIR_ACC, `OAT_S_DIR_IMM} ||
			(op inside {`OAT_OP_INC, `OAT_OP_DEC} && src inside {`OAT_S_IND, `OAT_S_DIR});
		e.mw = op <= `OAT_OP_SUBTRACT_BORROW_OP || op inside {[`OAT_OP_AND:`OAT_OP_XOR]} || e.wr;
		e.ma = op <= `OAT_OP_SUBTRACT_BORROW_OP;
		opd = src == `OAT_S_IMM ? imm_i : mem_data_i;
		case (op)
		`OAT_OP_ADD: e.al = {1'b0, acc_i} + {1'b0, opd};
		`OAT_OP_ADD_WITH_CARRY_OP: e.al = {1'b0, acc_i} + {1'b0, opd} + borrow_i;
		default: e.al = {1'b0, acc_i} - {1'b0, opd} - borrow_i;
		endcase
		q.push_back(e);
		start_i = 1;
		@(negedge mclk_i);
		if (hold) @(negedge mclk_i);
		if (done_o !== 1'b1) start_i = 0;
		for (k = 0; k < 12 && done_o !== 1'b1; k++) @(negedge mclk_i);
		if (k == 12) fail("no completion");
	endtask
	always @(negedge mclk_i) if (done_o === 1'b1) begin
		oat_exp_t e;
		if (q.size() == 0) fail("unexpected completion");
		else begin
			e = q.pop_front();
			checked++;
			if (e.ms && {space_o, addr_o} !== {e.sp, e.ad})
				fail("address");
			if ({bytes_o, cycles_o} !== e.bc)
				fail("counts");
			if (e.mw && wr_o !== e.wr) fail("writeback");
			if (e.mw && result_to_mem_o !== e.wr) fail("result target");
			if (e.ma && {carry_o, alu_o} !== e.al) fail("add group result");
		end
	end
	initial begin
		int i;
		logic [3:0] op;
		logic [2:0] src;
		i = $urandom(2937);
		repeat (10) @(negedge mclk_i);
		rst_i = 0;
		checked++;
		if (space_o !== `OAT_SP_NONE || done_o !== 1'b0) fail("reset state");
		for (i = 0; i < 400; i++) begin
			op = i < 39 ? 4'(i % 13) : 4'($urandom_range(12));
			src = 3'($urandom_range(4, 1));
			if (op inside {`OAT_OP_INC, `OAT_OP_DEC}) src = 3'($urandom_range(3));
			if (op inside {[`OAT_OP_AND:`OAT_OP_XOR]}) src = 3'($urandom_range(6, 1));
			if (op inside {[`OAT_OP_INCDP:`OAT_OP_DIV], `OAT_OP_XMOVE, `OAT_OP_CFETCH}) src = 3'h0;
			issue(op, src, op == `OAT_OP_MUL, i < 40 ? 8'h7f + i[0] : 8'($urandom));
		end
		start_i = 0;
		repeat (2) @(negedge mclk_i);
		if (q.size() != 0) fail("missing completion");
		tally_and_finish;
	end
	initial begin
		#100us;
		fail("timeout");
		tally_and_finish;
	end
endmodule
`default_nettype wire

/* File: oat_timing.v */
`default_nettype none
`include "oat_consts.vh"
module oat_timing (
	// operation
	input  wire [3:0] op_i,
	input  wire [2:0] src_i,
	// counts
	output reg  [1:0] bytes_o,
	output reg  [3:0] cycles_o
);
	always @* begin
		bytes_o  = `OAT_BYTES_ONE;
		cycles_o = `OAT_CYC_ONE;
		case (op_i)
		`OAT_OP_ADD, `OAT_OP_ADD_WITH_CARRY_OP, `OAT_OP_SUBTRACT_BORROW_OP, `OAT_OP_AND, `OAT_OP_OR,
		`OAT_OP_XOR: begin
			case (src_i)
			`OAT_S_BANK, `OAT_S_ACC: begin
				bytes_o  = `OAT_BYTES_ONE;
				cycles_o = `OAT_CYC_ONE;
			end
			`OAT_S_IND: begin
				bytes_o  = `OAT_BYTES_ONE;
				cycles_o = `OAT_CYC_TWO;
			end
			`OAT_S_DIR_ACC: begin
				bytes_o  = `OAT_BYTES_TWO;
				cycles_o = `OAT_CYC_TWO;
			end
			`OAT_S_DIR_IMM: begin
				bytes_o  = `OAT_BYTES_THREE;
				cycles_o = `OAT_CYC_THREE;
			end
			default: begin
				bytes_o  = `OAT_BYTES_TWO;
				cycles_o = `OAT_CYC_TWO;
			end
			endcase
		end
		`OAT_OP_INC, `OAT_OP_DEC: begin
			case (src_i)
			`OAT_S_ACC, `OAT_S_BANK: cycles_o = `OAT_CYC_ONE;
			`OAT_S_IND:              cycles_o = `OAT_CYC_TWO;
			default: begin
				bytes_o  = `OAT_BYTES_TWO;
				cycles_o = `OAT_CYC_TWO;
			end
			endcase
		end
		`OAT_OP_INCDP: cycles_o = `OAT_CYC_THREE;
		`OAT_OP_MUL, `OAT_OP_DIV: cycles_o = `OAT_CYC_NINE;
		`OAT_OP_XMOVE, `OAT_OP_CFETCH: cycles_o = `OAT_CYC_FOUR;
		default: cycles_o = `OAT_CYC_ONE;
		endcase
	end
endmodule
`default_nettype wire
